//--- rtl/rfsup_pkg.sv
// Constants and carrier types for the regulator fault supervisor
package rfsup_pkg;
	// -----------------------------------------------------------------
	// Clock and times
	// -----------------------------------------------------------------
	localparam int CLK_NS       = 50;
	localparam int UV_FILT_NS   = 4000;   // Least window, rounded up
	localparam int OV_FILT_NS   = 128000;
	localparam int OC_FILT_NS   = 1000;
	localparam int IRQ_LONG_NS  = 100000;
	localparam int IRQ_SHORT_NS = 25000;
	localparam int IRQ_GAP_NS   = 1000;
	localparam int WAKE_NS      = 60000;
	localparam int MUX_RDY_NS   = 10000;  // Longest, rounded down
	localparam int CW           = 12;
	localparam logic [CW-1:0] UV_CYC  = CW'((UV_FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] OV_CYC  = CW'((OV_FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] OC_CYC  = CW'((OC_FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] IRQ_L_CYC = CW'((IRQ_LONG_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] IRQ_S_CYC = CW'((IRQ_SHORT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] GAP_CYC = CW'((IRQ_GAP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] WAKE_CYC = CW'((WAKE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] MUX_CYC = CW'(MUX_RDY_NS / CLK_NS);
	localparam logic [2:0]    TOPO_CYC = 3'h4;

	// -----------------------------------------------------------------
	// Register map (byte addresses)
	// -----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS  = 4'h0;
	localparam logic [3:0] DIAG_OFS  = 4'h4;
	localparam logic [3:0] STATE_OFS = 4'h8;
	// Control fields
	localparam int C_EN      = 0;  // [2:0] core, aref, aux enables
	localparam int C_EXTPASS = 3;
	localparam int C_IRQLONG = 4;
	localparam int C_IRQEN   = 5;
	localparam int C_SC      = 6;  // [8:6] safety critical
	localparam int C_MUX     = 9;  // [11:9] mux source
	localparam logic [11:0] CTRL_RST = 12'h037;
	// Diagnostic fields
	localparam int D_BATT = 8;
	localparam int D_WAKE = 9;
	// State fields
	localparam int S_BATT = 8;
	localparam int S_TOPO = 9;
	localparam int S_MRDY = 10;
	localparam int S_IO   = 11;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic       oc_aux;
		logic       oc_aref;
		logic [2:0] ov;  // aux, aref, core
		logic [2:0] uv;  // aux, aref, core
	} rfsup_det_t;

	typedef enum logic [2:0] {
		IRQ_IDLE  = 3'b001,
		IRQ_PULSE = 3'b010,
		IRQ_GAP   = 3'b100
	} rfsup_irq_t;
endpackage : rfsup_pkg

//--- rtl/rfsup_top.sv
// Regulator fault supervisor: filters, supply control, diagnostics, irq
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module rfsup_top (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Avalon-MM slave
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// Analog detectors, asynchronous
	input  wire rfsup_pkg::rfsup_det_t det_raw,
	input  wire logic                batt_low_raw,
	input  wire logic                low_side_gate,
	input  wire logic [5:0]          io_in,
	// Regulator and pin controls
	output logic                     pre_regulator_en,
	output logic                     buck_boost_mode,
	output logic                     core_supply_en,
	output logic                     analog_ref_supply_en,
	output logic                     aux_supply_en,
	output logic [2:0]               analog_mux_sel,
	output logic                     analog_mux_ready,
	output logic                     batt_warn,
	output logic                     wake_req,
	output logic                     irq_pulse_n,
	output logic                     reset_out_n,
	output logic                     failsafe_out_n
);
	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	localparam int NS = 16;
	logic [NS-1:0] sync1_ff;
	logic [NS-1:0] sync2_ff;
	logic [7:0]    det_s;
	logic          batt_s;
	logic          lsg_s;
	logic [5:0]    io_s;

	// Two stages; only the second is read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {io_in, low_side_gate, batt_low_raw, det_raw};
			sync2_ff <= sync1_ff;
		end
	end
	assign det_s  = sync2_ff[7:0];
	assign batt_s = sync2_ff[8];
	assign lsg_s  = sync2_ff[9];
	assign io_s   = sync2_ff[15:10];

	// -----------------------------------------------------------------
	// Detector filters
	// -----------------------------------------------------------------
	logic [7:0] flt;
	logic [7:0] flt_d_ff;
	logic [7:0] flt_rise;

	for (genvar g = 0; g < 8; g++) begin : g_flt
		localparam logic [rfsup_pkg::CW-1:0] THR = (g < 3) ? rfsup_pkg::UV_CYC :
			(g < 6) ? rfsup_pkg::OV_CYC : rfsup_pkg::OC_CYC;
		logic [rfsup_pkg::CW-1:0] cnt_ff;
		logic                     hit_ff;
		// Any gap in the raw level starts the window over
		always_ff @(posedge sys_clk) begin
			if (rst || !det_s[g]) begin
				cnt_ff <= '0;
				hit_ff <= 1'b0;
			end else if (cnt_ff == THR - 1'b1) begin
				hit_ff <= 1'b1;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
		assign flt[g] = hit_ff;
	end

	// Edge of each filtered flag, used as a one-shot event
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flt_d_ff <= '0;
		end else begin
			flt_d_ff <= flt;
		end
	end
	assign flt_rise = flt & ~flt_d_ff;

	// -----------------------------------------------------------------
	// Wake-up deglitch and battery warning
	// -----------------------------------------------------------------
	logic [5:0] io_ack;
	logic [5:0] wake_ev;
	logic       batt_ff;
	logic       batt_rise;

	for (genvar w = 0; w < 6; w++) begin : g_wake
		logic [rfsup_pkg::CW-1:0] cnt_ff;
		logic                     lvl_ff;
		logic                     ev_ff;
		// New level must hold the full deglitch time to count
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				cnt_ff <= '0;
				lvl_ff <= 1'b0;
				ev_ff  <= 1'b0;
			end else if (io_s[w] == lvl_ff) begin
				cnt_ff <= '0;
				ev_ff  <= 1'b0;
			end else if (cnt_ff == rfsup_pkg::WAKE_CYC - 1'b1) begin
				cnt_ff <= '0;
				lvl_ff <= io_s[w];
				ev_ff  <= 1'b1;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
				ev_ff  <= 1'b0;
			end
		end
		assign io_ack[w]  = lvl_ff;
		assign wake_ev[w] = ev_ff;
	end

	// Comparator level is already debounced in the analog front end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			batt_ff <= 1'b0;
		end else begin
			batt_ff <= batt_s;
		end
	end
	assign batt_rise = batt_s & ~batt_ff;

	// -----------------------------------------------------------------
	// Register bus
	// -----------------------------------------------------------------
	logic        req;
	logic        acc;
	logic        wr_ctrl;
	logic        wr_diag;
	logic [11:0] ctrl_ff;
	logic [11:0] nxt_ctrl;
	logic [9:0]  diag_ff;
	logic [9:0]  diag_set;
	logic [9:0]  diag_clr;
	logic [31:0] rd_mux;
	logic [2:0]  en_ff;
	logic        wait_ff;
	logic [31:0] rdata_ff;

	assign req     = avs_read | avs_write;
	assign acc     = req & ~wait_ff; // Edge where the master sees the answer
	assign wr_ctrl = acc & avs_write & (avs_address == rfsup_pkg::CTRL_OFS);
	assign wr_diag = acc & avs_write & (avs_address == rfsup_pkg::DIAG_OFS);

	// One wait cycle per access; readdata loaded with the release
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wait_ff  <= 1'b1;
			rdata_ff <= '0;
		end else begin
			wait_ff <= ~(req & wait_ff);
			if (req & wait_ff & avs_read) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	// Read decode; unmapped words read as zero
	always_comb begin
		rd_mux = '0;
		unique case (avs_address)
			rfsup_pkg::CTRL_OFS:  rd_mux = {20'h00000, ctrl_ff[11:3], en_ff};
			rfsup_pkg::DIAG_OFS:  rd_mux = {22'h0, diag_ff};
			rfsup_pkg::STATE_OFS: rd_mux = {15'h0, io_ack, analog_mux_ready,
				buck_boost_mode, batt_ff, flt};
			default:              rd_mux = '0;
		endcase
	end

	// Byte-lane merge of control writes
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_ctrl[2:0] = en_ff;
		if (avs_byteenable[0]) begin
			nxt_ctrl[7:0] = avs_writedata[7:0];
		end
		if (avs_byteenable[1]) begin
			nxt_ctrl[11:8] = avs_writedata[11:8];
		end
	end

	// Configuration fields other than the enables
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_ff <= rfsup_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// -----------------------------------------------------------------
	// Supply enables
	// -----------------------------------------------------------------
	logic [2:0] off_ev;

	// Overcurrent only trips aref when it drives the external pass device
	assign off_ev[0] = flt[3];
	assign off_ev[1] = flt[4] | (flt[6] & ctrl_ff[rfsup_pkg::C_EXTPASS]);
	assign off_ev[2] = flt[5] | flt[7];

	// Fault beats a same-cycle turn-on, so a live fault cannot be forced on
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			en_ff <= 3'h7;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (off_ev[i]) begin
					en_ff[i] <= 1'b0;
				end else if (wr_ctrl && avs_byteenable[0]) begin
					en_ff[i] <= avs_writedata[i];
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Diagnostics, sticky, write one to clear; set wins
	// -----------------------------------------------------------------
	assign diag_set = {|wake_ev, batt_rise, flt_rise};
	assign diag_clr = (wr_diag && avs_byteenable[0]) ?
		{avs_byteenable[1] ? avs_writedata[9:8] : 2'h0, avs_writedata[7:0]} : 10'h000;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			diag_ff <= '0;
		end else begin
			diag_ff <= (diag_ff & ~diag_clr) | diag_set;
		end
	end

	// -----------------------------------------------------------------
	// Interrupt pulse generator
	// -----------------------------------------------------------------
	rfsup_pkg::rfsup_irq_t irq_st_ff;
	logic [rfsup_pkg::CW-1:0] irq_cnt_ff;
	logic                     irq_pend_ff;
	logic                     irq_ev;
	logic                     irq_n_ff;

	// Wake events are logged but only supply and battery events interrupt
	assign irq_ev = |{batt_rise, flt_rise};

	// Events during a pulse are merged into one further pulse
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_pend_ff <= 1'b0;
		end else if (irq_ev && ctrl_ff[rfsup_pkg::C_IRQEN]) begin
			irq_pend_ff <= 1'b1;
		end else if (irq_st_ff == rfsup_pkg::IRQ_IDLE) begin
			irq_pend_ff <= 1'b0;
		end
	end

	// Low pulse, then a short high gap so pulses stay separable
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_st_ff  <= rfsup_pkg::IRQ_IDLE;
			irq_cnt_ff <= '0;
			irq_n_ff   <= 1'b1;
		end else begin
			unique case (irq_st_ff)
				rfsup_pkg::IRQ_IDLE: begin
					if (irq_pend_ff) begin
						irq_st_ff  <= rfsup_pkg::IRQ_PULSE;
						irq_n_ff   <= 1'b0;
						irq_cnt_ff <= ctrl_ff[rfsup_pkg::C_IRQLONG] ?
							rfsup_pkg::IRQ_L_CYC : rfsup_pkg::IRQ_S_CYC;
					end
				end
				rfsup_pkg::IRQ_PULSE: begin
					if (irq_cnt_ff == 12'h001) begin
						irq_st_ff  <= rfsup_pkg::IRQ_GAP;
						irq_n_ff   <= 1'b1;
						irq_cnt_ff <= rfsup_pkg::GAP_CYC;
					end else begin
						irq_cnt_ff <= irq_cnt_ff - 1'b1;
					end
				end
				rfsup_pkg::IRQ_GAP: begin
					if (irq_cnt_ff == 12'h001) begin
						irq_st_ff <= rfsup_pkg::IRQ_IDLE;
					end else begin
						irq_cnt_ff <= irq_cnt_ff - 1'b1;
					end
				end
				default: begin
					irq_st_ff <= rfsup_pkg::IRQ_IDLE;
					irq_n_ff  <= 1'b1;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Safety outputs, mux settling, topology
	// -----------------------------------------------------------------
	logic [2:0] sc_flt;
	logic       rst_n_ff;
	logic       fs_n_ff;
	logic [rfsup_pkg::CW-1:0] mux_cnt_ff;
	logic       mux_rdy_ff;
	logic [2:0] topo_cnt_ff;
	logic       topo_ff;

	// Undervoltage or overvoltage of a safety-critical supply pulls both lines low; overcurrent does not
	assign sc_flt = (flt[2:0] | flt[5:3]) & ctrl_ff[8:6];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rst_n_ff <= 1'b1;
			fs_n_ff  <= 1'b1;
		end else begin
			rst_n_ff <= ~|sc_flt;
			fs_n_ff  <= ~|sc_flt;
		end
	end

	// Ready drops on a new source and returns inside the settling limit
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mux_cnt_ff <= '0;
			mux_rdy_ff <= 1'b1;
		end else if (wr_ctrl && avs_byteenable[1] &&
				avs_writedata[11:9] != ctrl_ff[11:9]) begin
			mux_cnt_ff <= rfsup_pkg::MUX_CYC - 1'b1;
			mux_rdy_ff <= 1'b0;
		end else if (mux_cnt_ff != '0) begin
			mux_cnt_ff <= mux_cnt_ff - 1'b1;
		end else begin
			mux_rdy_ff <= 1'b1;
		end
	end

	// Gate pin sampled once, after the synchroniser has settled
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			topo_cnt_ff <= '0;
			topo_ff     <= 1'b0;
		end else if (topo_cnt_ff != rfsup_pkg::TOPO_CYC) begin
			topo_cnt_ff <= topo_cnt_ff + 1'b1;
			if (topo_cnt_ff == rfsup_pkg::TOPO_CYC - 1'b1) begin
				topo_ff <= lsg_s;
			end
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	logic pre_en_ff;
	logic wake_ff;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pre_en_ff <= 1'b1;
			wake_ff   <= 1'b0;
		end else begin
			pre_en_ff <= 1'b1;
			wake_ff   <= diag_ff[rfsup_pkg::D_WAKE];
		end
	end

	assign avs_readdata         = rdata_ff;
	assign avs_waitrequest      = wait_ff;
	assign pre_regulator_en     = pre_en_ff;
	assign buck_boost_mode      = topo_ff;
	assign core_supply_en       = en_ff[0];
	assign analog_ref_supply_en = en_ff[1];
	assign aux_supply_en        = en_ff[2];
	assign analog_mux_sel       = ctrl_ff[11:9];
	assign analog_mux_ready     = mux_rdy_ff;
	assign batt_warn            = batt_ff;
	assign wake_req             = wake_ff;
	assign irq_pulse_n          = irq_n_ff;
	assign reset_out_n          = rst_n_ff;
	assign failsafe_out_n       = fs_n_ff;
endmodule : rfsup_top

//--- test/rfsup_chk.sv
// Port checker for the regulator fault supervisor
`timescale 1ns/1ps
module rfsup_chk (
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  rst,
	// Bus handshake
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic                  avs_waitrequest,
	// Detectors
	input wire rfsup_pkg::rfsup_det_t det_raw,
	input wire logic                  batt_low_raw,
	// Supply and pin outputs
	input wire logic                  pre_regulator_en,
	input wire logic                  core_supply_en,
	input wire logic                  analog_ref_supply_en,
	input wire logic                  aux_supply_en,
	input wire logic                  analog_mux_ready,
	input wire logic                  batt_warn,
	input wire logic                  irq_pulse_n,
	input wire logic                  reset_out_n,
	input wire logic                  failsafe_out_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	logic [12:0] run_ff [8];
	logic [12:0] quiet_ff;
	logic [12:0] low_ff;
	// Raw run lengths, saturating so long faults never wrap
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 8; i++) begin
			if (rst || !det_raw[i])
				run_ff[i] <= 13'h0;
			else if (run_ff[i] != 13'h1FFF)
				run_ff[i] <= run_ff[i] + 13'h1;
		end
	end
	// Quiet time of uv/ov detectors and irq low time
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			quiet_ff <= 13'h0;
			low_ff   <= 13'h0;
		end else begin
			quiet_ff <= (det_raw[5:0] != 6'h0) ? 13'h0 : quiet_ff + {12'h0, quiet_ff != 13'h1FFF};
			low_ff   <= irq_pulse_n ? 13'h0 : low_ff + 13'h1;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_en_reset: assert property ($fell(rst) |-> pre_regulator_en && core_supply_en
		&& analog_ref_supply_en && aux_supply_en && irq_pulse_n && reset_out_n)
		else $error("supplies not on after reset");
	a_filter_min: assert property ($fell(reset_out_n) |->
		run_ff[0] >= 13'h50 || run_ff[1] >= 13'h50 || run_ff[2] >= 13'h50
		|| run_ff[3] >= 13'hA00 || run_ff[4] >= 13'hA00 || run_ff[5] >= 13'hA00)
		else $error("fault reported before its filter ran");
	a_core_ov: assert property (run_ff[3] == 13'h1248 |-> !core_supply_en)
		else $error("core on through long overvoltage");
	a_aref_ov: assert property (run_ff[4] == 13'h1248 |-> !analog_ref_supply_en)
		else $error("aref on through long overvoltage");
	a_aux_off: assert property (run_ff[5] == 13'h1248 || run_ff[7] == 13'h3C
		|-> !aux_supply_en)
		else $error("aux on through fault");
	a_sc_clear: assert property (quiet_ff >= 13'h6 |-> reset_out_n && failsafe_out_n)
		else $error("safety outputs low without fault");
	a_irq_width: assert property ($rose(irq_pulse_n) |-> low_ff >= 13'h190)
		else $error("irq pulse too short");
	a_batt_lat: assert property (batt_low_raw [*4] |-> batt_warn)
		else $error("battery warning late");
	a_mux_back: assert property ($fell(analog_mux_ready) |-> ##[1:200] analog_mux_ready)
		else $error("mux not ready in time");
	// Main scenarios seen
	c_irq: cover property ($fell(irq_pulse_n));
	c_safe: cover property ($fell(reset_out_n));
	c_mux: cover property ($fell(analog_mux_ready));
endmodule : rfsup_chk

//--- test/rfsup_mcu.sv
// Microcontroller model: bus master and interrupt watcher
`timescale 1ns/1ps
module rfsup_mcu (
	// Clock
	input  wire logic        sys_clk,
	// Avalon-MM master side
	output logic [3:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	output logic [3:0]       avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	// Interrupt line
	input  wire logic        irq_pulse_n
);
	// Idle bus from time zero
	initial begin
		avs_address    = 4'h0;
		avs_read       = 1'h0;
		avs_write      = 1'h0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hF;
	end
	// One transfer, held until waitrequest is seen low
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q, output bit tmo);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= rd;
		avs_write     <= !rd;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 40);
		q = avs_readdata;
		tmo = (n >= 40);
		avs_read  <= 1'h0;
		avs_write <= 1'h0;
	endtask : xfer
	// Cycles to the falling edge, then low length
	task automatic irq_watch(output int dly, output int len, output bit tmo);
		dly = 0;
		len = 0;
		while (irq_pulse_n !== 1'h0 && dly < 6000) begin
			@(posedge sys_clk);
			dly++;
		end
		while (irq_pulse_n === 1'h0 && len < 3000) begin
			@(posedge sys_clk);
			len++;
		end
		tmo = (dly >= 6000 || len >= 3000);
	endtask : irq_watch
endmodule : rfsup_mcu

//--- test/rfsup_top_tb.sv
// Self-checking bench for the regulator fault supervisor
`timescale 1ns/1ps
module rfsup_top_tb;
	logic                  sys_clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]            avs_address, avs_byteenable;
	logic [31:0]           avs_writedata, avs_readdata;
	rfsup_pkg::rfsup_det_t det_raw;
	logic                  batt_low_raw, low_side_gate, wake_req, batt_warn;
	logic [5:0]            io_in;
	logic                  pre_regulator_en, buck_boost_mode, core_supply_en;
	logic                  analog_ref_supply_en, aux_supply_en, analog_mux_ready;
	logic [2:0]            analog_mux_sel;
	logic                  irq_pulse_n, reset_out_n, failsafe_out_n;
	int                    n_errors = 0;
	int                    n_checks = 0;
	rfsup_top i_rfsup_top (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .det_raw, .batt_low_raw,
		.low_side_gate, .io_in, .pre_regulator_en, .buck_boost_mode, .core_supply_en,
		.analog_ref_supply_en, .aux_supply_en, .analog_mux_sel, .analog_mux_ready,
		.batt_warn, .wake_req, .irq_pulse_n, .reset_out_n, .failsafe_out_n);
	rfsup_mcu i_rfsup_mcu (.sys_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_pulse_n);
	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk_word
	task automatic chk_bit(string nm, logic e, logic g);
		chk_word(nm, {31'h0, e}, {31'h0, g});
	endtask : chk_bit
	task automatic chk_range(string nm, int lo, int hi, int g);
		n_checks++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask : chk_range
	// A spent wait counts as a mismatch and ends the run
	task automatic chk_tmo(bit t);
		if (t) begin
			n_errors++;
			$display("unexpected timeout");
			results();
		end
	endtask : chk_tmo
	task automatic wr(logic [3:0] a, logic [31:0] d);
		logic [31:0] q;
		bit          t;
		i_rfsup_mcu.xfer(1'h0, a, d, q, t);
		chk_tmo(t);
	endtask : wr
	task automatic rd(logic [3:0] a, logic [31:0] m, logic [31:0] e, string nm);
		logic [31:0] q;
		bit          t;
		i_rfsup_mcu.xfer(1'h1, a, 32'h0, q, t);
		chk_tmo(t);
		chk_word(nm, e, q & m);
	endtask : rd
	task automatic irq(int lo, int hi, int len);
		int d;
		int l;
		bit t;
		i_rfsup_mcu.irq_watch(d, l, t);
		chk_tmo(t);
		chk_range("irq delay", lo, hi, d);
		chk_range("irq length", len, len, l);
	endtask : irq
	task automatic tick(int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		rst = 1'h1;
		det_raw = '0;
		batt_low_raw = 1'h0;
		low_side_gate = 1'h1;
		io_in = 6'h0;
		tick(5);
		rst <= 1'h0;
		tick(6);
		#1;
		chk_bit("buck boost", 1'h1, buck_boost_mode);
		chk_word("enables", 32'hF, {28'h0, pre_regulator_en, aux_supply_en,
			analog_ref_supply_en, core_supply_en});
		rd(rfsup_pkg::CTRL_OFS, 32'hFFFFFFFF, {20'h0, rfsup_pkg::CTRL_RST}, "ctrl");
		rd(4'hC, 32'hFFFFFFFF, 32'h0, "unmapped");
		// Each supply switched off and on by command
		for (int i = 0; i < 3; i++) begin
			wr(rfsup_pkg::CTRL_OFS, 32'h37 ^ (32'h1 << i));
			#1;
			chk_word("enable off", {29'h0, 3'h7 ^ (3'h1 << i)},
				{29'h0, aux_supply_en, analog_ref_supply_en, core_supply_en});
			wr(rfsup_pkg::CTRL_OFS, 32'h37);
			#1;
			chk_word("enable on", 32'h7,
				{29'h0, aux_supply_en, analog_ref_supply_en, core_supply_en});
			tick(1);
		end
		// Short undervoltage glitch must not shorten the next window
		det_raw.uv[0] <= 1'h1;
		tick(60);
		det_raw.uv[0] <= 1'h0;
		tick(2);
		det_raw.uv[0] <= 1'h1;
		irq(80, 200, 2000);
		#1;
		chk_bit("reset out", 1'h1, reset_out_n);
		rd(rfsup_pkg::DIAG_OFS, 32'h1, 32'h1, "diag uv");
		det_raw.uv[0] <= 1'h0;
		tick(10);
		wr(rfsup_pkg::DIAG_OFS, 32'h1);
		rd(rfsup_pkg::DIAG_OFS, 32'h1, 32'h0, "diag clear");
		// Short pulse setting, aux and aref overvoltage held past the longest window
		wr(rfsup_pkg::CTRL_OFS, 32'h27);
		det_raw.ov[2] <= 1'h1;
		det_raw.ov[1] <= 1'h1;
		irq(2560, 4680, 500);
		#1;
		chk_bit("aux fault off", 1'h0, aux_supply_en);
		chk_bit("aref fault off", 1'h0, analog_ref_supply_en);
		rd(rfsup_pkg::DIAG_OFS, 32'h30, 32'h30, "diag ov aux aref");
		tick(1620);
		det_raw.ov[2] <= 1'h0;
		det_raw.ov[1] <= 1'h0;
		tick(20);
		#1;
		chk_bit("aux stays off", 1'h0, aux_supply_en);
		chk_bit("aref stays off", 1'h0, analog_ref_supply_en);
		wr(rfsup_pkg::CTRL_OFS, 32'h37);
		#1;
		chk_bit("aux back on", 1'h1, aux_supply_en);
		chk_bit("aref back on", 1'h1, analog_ref_supply_en);
		// Core safety critical; here its overvoltage turns it off, not a command
		wr(rfsup_pkg::CTRL_OFS, 32'h77);
		det_raw.ov[0] <= 1'h1;
		irq(2560, 4680, 2000);
		#1;
		chk_bit("core fault off", 1'h0, core_supply_en);
		chk_bit("reset out", 1'h0, reset_out_n);
		chk_bit("failsafe out", 1'h0, failsafe_out_n);
		// Hold past the longest window so the disable is watched there too
		tick(120);
		det_raw.ov[0] <= 1'h0;
		tick(10);
		#1;
		chk_bit("reset out", 1'h1, reset_out_n);
		wr(rfsup_pkg::CTRL_OFS, 32'h37);
		#1;
		chk_bit("core back on", 1'h1, core_supply_en);
		// Aref overcurrent acts only with the external pass device
		for (int p = 0; p < 2; p++) begin
			wr(rfsup_pkg::CTRL_OFS, (p == 1) ? 32'h3F : 32'h37);
			det_raw.oc_aref <= 1'h1;
			det_raw.oc_aux  <= 1'h1;
			irq(0, 200, 2000);
			#1;
			chk_bit("aref on oc", (p == 0), analog_ref_supply_en);
			chk_bit("aux on oc", 1'h0, aux_supply_en);
			tick(1);
			det_raw.oc_aref <= 1'h0;
			det_raw.oc_aux  <= 1'h0;
			tick(30);
		end
		wr(rfsup_pkg::CTRL_OFS, 32'h37);
		// Battery early warning
		batt_low_raw <= 1'h1;
		irq(0, 50, 2000);
		#1;
		chk_bit("batt warn", 1'h1, batt_warn);
		rd(rfsup_pkg::STATE_OFS, 32'h100, 32'h100, "state batt");
		batt_low_raw <= 1'h0;
		// Wake on I/O only after the deglitch time
		io_in <= 6'h21;
		tick(1190);
		#1;
		chk_bit("wake early", 1'h0, wake_req);
		tick(420);
		#1;
		chk_bit("wake", 1'h1, wake_req);
		rd(rfsup_pkg::STATE_OFS, 32'h1F800, 32'h10800, "io level");
		// Mux source change
		wr(rfsup_pkg::CTRL_OFS, 32'h637);
		tick(2);
		#1;
		chk_bit("mux busy", 1'h0, analog_mux_ready);
		tick(199);
		#1;
		chk_bit("mux ready", 1'h1, analog_mux_ready);
		chk_word("mux sel", 32'h3, {29'h0, analog_mux_sel});
		// Second reset with supplies off and the gate pin open: plain buck
		wr(rfsup_pkg::CTRL_OFS, 32'h630);
		rst           <= 1'h1;
		low_side_gate <= 1'h0;
		tick(5);
		rst <= 1'h0;
		tick(6);
		#1;
		chk_bit("buck", 1'h0, buck_boost_mode);
		chk_word("enables again", 32'hF, {28'h0, pre_regulator_en, aux_supply_en,
			analog_ref_supply_en, core_supply_en});
		results();
	end
endmodule : rfsup_top_tb

bind rfsup_top rfsup_chk i_rfsup_chk (.sys_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
	.det_raw, .batt_low_raw, .pre_regulator_en, .core_supply_en, .analog_ref_supply_en,
	.aux_supply_en, .analog_mux_ready, .batt_warn, .irq_pulse_n, .reset_out_n,
	.failsafe_out_n);
